// File: core/rft_pkg.sv
// Constants and types for the RF front-end trim register bank
`default_nettype none
package rft_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_SWITCH_RAMP = 6'h08;
   localparam logic [5:0] IDX_PUMP_CUR = 6'h09;
   localparam logic [5:0] IDX_IF_HIGH = 6'h0a;
   localparam logic [5:0] IDX_IF_LOW = 6'h0b;
   localparam logic [5:0] IDX_IF_ASSESS_HIGH = 6'h0c;
   localparam logic [5:0] IDX_IF_ASSESS_LOW = 6'h0d;
   localparam logic [5:0] IDX_BPF_HIGH = 6'h0e;
   localparam logic [5:0] IDX_BPF_LOW = 6'h0f;
   localparam logic [5:0] IDX_BPF_ASSESS_HIGH = 6'h10;
   localparam logic [5:0] IDX_BPF_ASSESS_LOW = 6'h11;
   localparam logic [5:0] IDX_RSSI_TRIM = 6'h12;
   localparam logic [5:0] IDX_PA_FINE = 6'h13;
   localparam logic [5:0] IDX_AMP_CTRL_CFG = 6'h20;
   localparam logic [5:0] IDX_FRONTEND_STATUS = 6'h21;
   localparam int BANK_FIRST = 8;
   localparam int BANK_COUNT = 12;
   // Reset values, bank order
   localparam logic [7:0] RST_SWITCH_RAMP = 8'h00;
   localparam logic [7:0] RST_PUMP_CUR = 8'h44;
   localparam logic [7:0] RST_IF_HIGH = 8'h14;
   localparam logic [7:0] RST_IF_LOW = 8'h47;
   localparam logic [7:0] RST_BPF_HIGH = 8'h02;
   localparam logic [7:0] RST_BPF_LOW = 8'h04;
   localparam logic [7:0] RST_BPF_ASSESS_HIGH = 8'h01;
   localparam logic [7:0] RST_BPF_ASSESS_LOW = 8'h10;
   localparam logic [7:0] RST_RSSI_TRIM = 8'h1f;
   localparam logic [7:0] RST_PA_FINE = 8'h10;
   localparam logic [7:0] RST_AMP_CTRL_CFG = 8'h00;
   // Field positions
   localparam int POS_ANT_MODE = 7;
   localparam int POS_TXRX_MODE = 6;
   localparam int POS_AMP_ENABLE = 4;
   localparam int POS_AMP_TIMING = 7;
   localparam int POS_AMP_POLARITY = 6;
   localparam int POS_PUMP_TX = 4;
   localparam int POS_PUMP_RX = 0;
   // Ramp timing in ns, at a 20 ns clock
   localparam int CLK_PERIOD_NS = 20;
   localparam int RAMP_BASE_NS = 9000;
   localparam int RAMP_FIRST_NS = 10100;
   localparam int RAMP_STEP_NS = 1071;
   localparam int RAMP_BASE_CYC = (RAMP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Data rate codes allowed with the narrowband option (50/100/200 kbps)
   localparam logic [2:0] RATE_50K = 3'h3;
   localparam logic [2:0] RATE_100K = 3'h4;
   localparam logic [2:0] RATE_200K = 3'h6;
   typedef enum logic [2:0] {
      RFT_RAMP_IDLE = 3'b001,
      RFT_RAMP_RUN = 3'b010,
      RFT_RAMP_DONE = 3'b100
   } rft_ramp_state_t;
endpackage
`default_nettype wire

// File: core/rft_trim_regs.sv
// RF front-end trim register bank with Wishbone classic slave
`default_nettype none
// Functional notes
// - Bits 7 and 6 of the switch/ramp register pick push-pull (0) or open drain (1) for the two switch pins.
// - With bit 4 clear the amp control output is low in positive logic; set, it is high in the state picked by the timing bit.
// - Ramp code 0 gives the built-in 9 us ramp, code 1 about 10.1 us, code 15 about 25.1 us.
// - Each ramp code step lengthens the ramp by about 1.1 us, monotonically.
// - The pump register holds a transmit current in bits 6-4 and a receive current in bits 2-0, both 100.
// - The normal IF value is the high byte at 0x0a joined with the low byte at 0x0b.
// - The IF value in use is the written base value scaled by a factor chosen by the data rate code.
// - In channel assessment the IF value from 0x0c and 0x0d replaces the normal one.
// - The normal bandpass width is ten bits: bits 1-0 of 0x0e above the byte at 0x0f.
// - In channel assessment the bandpass width comes from 0x10 and 0x11 instead.
// - The RSSI trim holds six bits reset to 01_1111 under two reserved bits.
// - The regulator fine trim is five bits in bits 4-0, about 14 mV a step.
// - The polarity bit inverts the amp control output level.
// - The timing bit makes the amp control output follow transmit-on (0) or amp-on (1).
module rft_trim_regs
   import rft_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tx_on_state,
   input wire logic amp_on_state,
   input wire logic assess_active,
   input wire logic [2:0] rate_code,
   input wire logic narrowband_option,
   input wire logic antenna_switch_level,
   input wire logic txrx_switch_level,
   output logic antenna_switch_pin_o,
   output logic antenna_switch_pin_oe,
   output logic txrx_switch_pin_o,
   output logic txrx_switch_pin_oe,
   output logic ext_amp_ctrl_pin,
   output logic amp_ramp_done,
   output logic [2:0] pump_current_active,
   output logic [18:0] intermediate_freq_active,
   output logic [9:0] bandpass_width_active,
   output logic [5:0] signal_strength_lowpass_trim,
   output logic [4:0] amp_regulator_fine_code
);
   logic [7:0] bank_q [BANK_COUNT];
   logic [7:0] amp_cfg_q;
   logic [31:0] dat_q;
   logic ack_q;
   logic [10:0] ramp_cnt_q;
   rft_ramp_state_t ramp_q;
   logic amp_on_q;
   logic rate_bad_q;
   logic [7:0] status;
   logic req;
   logic [15:0] if_sel;
   logic [9:0] bpf_sel;

   // Reset value of a bank slot
   function automatic logic [7:0] reset_value(input int slot);
      unique case (slot)
         0: reset_value = RST_SWITCH_RAMP;
         1: reset_value = RST_PUMP_CUR;
         2, 4: reset_value = RST_IF_HIGH;
         3, 5: reset_value = RST_IF_LOW;
         6: reset_value = RST_BPF_HIGH;
         7: reset_value = RST_BPF_LOW;
         8: reset_value = RST_BPF_ASSESS_HIGH;
         9: reset_value = RST_BPF_ASSESS_LOW;
         10: reset_value = RST_RSSI_TRIM;
         default: reset_value = RST_PA_FINE;
      endcase
   endfunction

   // Ramp length in cycles; linear in code above zero so longer codes never shorten
   function automatic logic [10:0] ramp_cycles(input logic [3:0] code);
      int ns;
      ns = (code == 4'h0) ? RAMP_BASE_NS : RAMP_FIRST_NS + (int'(code) - 1) * RAMP_STEP_NS;
      ramp_cycles = 11'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   endfunction

   // Rate-dependent IF scaling, one doubling per step of rate code bits 1-0
   function automatic logic [18:0] if_scale(input logic [15:0] base, input logic [2:0] rate);
      if_scale = {3'h0, base} << rate[1:0];
   endfunction

   // Whether an address index falls inside the bank
   function automatic logic in_bank(input logic [5:0] idx);
      in_bank = (idx >= IDX_SWITCH_RAMP) && (idx <= IDX_PA_FINE);
   endfunction

   assign req = wb_cyc_i && wb_stb_i && !ack_q;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clock) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // Byte-wide bank writes; lane 0 only, upper lanes discarded
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < BANK_COUNT; i++) begin
            bank_q[i] <= reset_value(i);
         end
         amp_cfg_q <= RST_AMP_CTRL_CFG;
      end else if (req && wb_we_i && wb_sel_i[0]) begin
         if (in_bank(wb_adr_i[7:2])) begin
            bank_q[4'(wb_adr_i[7:2] - IDX_SWITCH_RAMP)] <= wb_dat_i[7:0];
         end else if (wb_adr_i[7:2] == IDX_AMP_CTRL_CFG) begin
            amp_cfg_q <= wb_dat_i[7:0];
         end
      end
   end

   // Live status: amp pin, ramp finished, illegal narrowband combination
   assign status = {5'h00, rate_bad_q, amp_ramp_done, ext_amp_ctrl_pin};

   // Read data latched with the ack; unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (rst) begin
         dat_q <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         if (in_bank(wb_adr_i[7:2])) begin
            dat_q <= {24'h00_0000, bank_q[4'(wb_adr_i[7:2] - IDX_SWITCH_RAMP)]};
         end else if (wb_adr_i[7:2] == IDX_AMP_CTRL_CFG) begin
            dat_q <= {24'h00_0000, amp_cfg_q};
         end else if (wb_adr_i[7:2] == IDX_FRONTEND_STATUS) begin
            dat_q <= {24'h00_0000, status};
         end else begin
            dat_q <= 32'h0000_0000;
         end
      end
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;

   // Flag software breaking the narrowband rate restriction
   always_ff @(posedge clock) begin
      if (rst) begin
         rate_bad_q <= 1'b0;
      end else begin
         rate_bad_q <= narrowband_option && !(rate_code == RATE_50K || rate_code == RATE_100K ||
            rate_code == RATE_200K);
      end
   end

   // Switch pin drivers: open drain only ever pulls low
   always_ff @(posedge clock) begin
      if (rst) begin
         antenna_switch_pin_o <= 1'b0;
         antenna_switch_pin_oe <= 1'b0;
         txrx_switch_pin_o <= 1'b0;
         txrx_switch_pin_oe <= 1'b0;
      end else begin
         antenna_switch_pin_o <= bank_q[0][POS_ANT_MODE] ? 1'b0 : antenna_switch_level;
         antenna_switch_pin_oe <= bank_q[0][POS_ANT_MODE] ? !antenna_switch_level : 1'b1;
         txrx_switch_pin_o <= bank_q[0][POS_TXRX_MODE] ? 1'b0 : txrx_switch_level;
         txrx_switch_pin_oe <= bank_q[0][POS_TXRX_MODE] ? !txrx_switch_level : 1'b1;
      end
   end

   // Amp control pin: enable, reference select, then polarity
   always_ff @(posedge clock) begin
      if (rst) begin
         ext_amp_ctrl_pin <= 1'b0;
      end else begin
         ext_amp_ctrl_pin <= (bank_q[0][POS_AMP_ENABLE] &&
            (amp_cfg_q[POS_AMP_TIMING] ? amp_on_state : tx_on_state))
            ^ amp_cfg_q[POS_AMP_POLARITY];
      end
   end

   // Ramp timer, started by the amp-on rising edge
   always_ff @(posedge clock) begin
      if (rst) begin
         ramp_q <= RFT_RAMP_IDLE;
         ramp_cnt_q <= 11'h000;
         amp_on_q <= 1'b0;
         amp_ramp_done <= 1'b0;
      end else begin
         amp_on_q <= amp_on_state;
         unique case (ramp_q)
            RFT_RAMP_IDLE: begin
               if (amp_on_state && !amp_on_q) begin
                  ramp_cnt_q <= ramp_cycles(bank_q[0][3:0]);
                  ramp_q <= RFT_RAMP_RUN;
               end
            end
            RFT_RAMP_RUN: begin
               if (!amp_on_state) begin
                  ramp_q <= RFT_RAMP_IDLE;
               end else if (ramp_cnt_q == 11'h001) begin
                  ramp_q <= RFT_RAMP_DONE;
                  amp_ramp_done <= 1'b1;
               end else begin
                  ramp_cnt_q <= ramp_cnt_q - 11'h001;
               end
            end
            RFT_RAMP_DONE: begin
               if (!amp_on_state) begin
                  ramp_q <= RFT_RAMP_IDLE;
                  amp_ramp_done <= 1'b0;
               end
            end
         endcase
      end
   end

   // Normal or assessment settings
   assign if_sel = assess_active ? {bank_q[4], bank_q[5]} : {bank_q[2], bank_q[3]};
   assign bpf_sel = assess_active ? {bank_q[8][1:0], bank_q[9]} : {bank_q[6][1:0], bank_q[7]};

   // Analog trim outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         pump_current_active <= 3'h0;
         intermediate_freq_active <= 19'h0_0000;
         bandpass_width_active <= 10'h000;
         signal_strength_lowpass_trim <= 6'h00;
         amp_regulator_fine_code <= 5'h00;
      end else begin
         pump_current_active <= tx_on_state ? bank_q[1][POS_PUMP_TX +: 3] : bank_q[1][POS_PUMP_RX +: 3];
         intermediate_freq_active <= if_scale(if_sel, rate_code);
         bandpass_width_active <= bpf_sel;
         signal_strength_lowpass_trim <= bank_q[10][5:0];
         amp_regulator_fine_code <= bank_q[11][4:0];
      end
   end

   // Assertions

   // Single-cycle ack, so a strobe still held in the ack cycle is not taken again in that cycle
   a_ack_one_cycle: assert property (@(posedge clock) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   // A lane-0 write to the pump register lands in its slot
   a_write_readback: assert property (@(posedge clock) disable iff (rst)
      (req && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == IDX_PUMP_CUR) |=> bank_q[1] == $past(wb_dat_i[7:0]))
      else $error("pump register write lost");

   // Disabled amp control stays low in positive logic
   a_amp_disabled_low: assert property (@(posedge clock) disable iff (rst)
      (!bank_q[0][POS_AMP_ENABLE] && !amp_cfg_q[POS_AMP_POLARITY])[*2] |-> !ext_amp_ctrl_pin)
      else $error("amp pin high while disabled");

   // Transmit-on reference, one register stage late
   a_amp_follows_tx: assert property (@(posedge clock) disable iff (rst)
      (bank_q[0][POS_AMP_ENABLE] && !amp_cfg_q[POS_AMP_TIMING] && !amp_cfg_q[POS_AMP_POLARITY])
      |=> ext_amp_ctrl_pin == $past(tx_on_state))
      else $error("amp pin not following transmit-on");

   // Negative logic turns the idle low into a high
   a_amp_polarity: assert property (@(posedge clock) disable iff (rst)
      (amp_cfg_q[POS_AMP_POLARITY] && !bank_q[0][POS_AMP_ENABLE]) |=> ext_amp_ctrl_pin)
      else $error("polarity not inverting");

   // Open drain never drives the antenna pin high
   a_open_drain_high: assert property (@(posedge clock) disable iff (rst)
      antenna_switch_pin_oe && antenna_switch_pin_o |-> !$past(bank_q[0][POS_ANT_MODE]))
      else $error("open drain drove high");

   // Code zero loads the built-in ramp length
   a_ramp_base_time: assert property (@(posedge clock) disable iff (rst)
      (ramp_q == RFT_RAMP_IDLE && amp_on_state && !amp_on_q && bank_q[0][3:0] == 4'h0)
      |=> ramp_cnt_q == 11'(RAMP_BASE_CYC))
      else $error("base ramp length wrong");

   // Last two counts of a held ramp end in done
   a_ramp_done_bound: assert property (@(posedge clock) disable iff (rst)
      (ramp_q == RFT_RAMP_RUN && ramp_cnt_q == 11'h002 && amp_on_state) ##1 amp_on_state |-> ##1 amp_ramp_done)
      else $error("ramp end missed");

   // Receive current outside transmit
   a_pump_rx_select: assert property (@(posedge clock) disable iff (rst)
      !tx_on_state |=> pump_current_active == $past(bank_q[1][2:0]))
      else $error("receive pump current not used");

   // Assessment IF replaces the normal one
   a_assess_if_select: assert property (@(posedge clock) disable iff (rst)
      (assess_active && rate_code == 3'h0) |=> intermediate_freq_active[15:0] == $past({bank_q[4], bank_q[5]}))
      else $error("assessment IF not used");

   // Open drain never drives the transmit/receive pin high
   a_txrx_open_drain: assert property (@(posedge clock) disable iff (rst)
      txrx_switch_pin_oe && txrx_switch_pin_o |-> !$past(bank_q[0][POS_TXRX_MODE]))
      else $error("open drain drove switch high");

   // Push-pull always drives the antenna pin
   a_ant_push_pull: assert property (@(posedge clock) disable iff (rst)
      !bank_q[0][POS_ANT_MODE] |=> antenna_switch_pin_oe)
      else $error("push-pull antenna pin released");

   // Push-pull always drives the transmit/receive pin
   a_txrx_push_pull: assert property (@(posedge clock) disable iff (rst)
      !bank_q[0][POS_TXRX_MODE] |=> txrx_switch_pin_oe)
      else $error("push-pull switch pin released");

   // Transmit current while transmitting
   a_pump_tx_select: assert property (@(posedge clock) disable iff (rst)
      tx_on_state |=> pump_current_active == $past(bank_q[1][POS_PUMP_TX +: 3]))
      else $error("transmit pump current not used");

   // Normal IF pairs high and low byte
   a_normal_if_pair: assert property (@(posedge clock) disable iff (rst)
      (!assess_active && rate_code == 3'h0) |=> intermediate_freq_active == {3'h0, $past({bank_q[2], bank_q[3]})})
      else $error("normal IF pairing wrong");

   // Rate code one doubles the base value
   a_if_rate_scale: assert property (@(posedge clock) disable iff (rst)
      (!assess_active && rate_code == 3'h1) |=> intermediate_freq_active == {2'h0, $past({bank_q[2], bank_q[3]}), 1'b0})
      else $error("IF not scaled by rate");

   // Normal bandpass width, two high bits over a byte
   a_bpf_normal: assert property (@(posedge clock) disable iff (rst)
      !assess_active |=> bandpass_width_active == $past({bank_q[6][1:0], bank_q[7]}))
      else $error("normal bandpass width wrong");

   // Assessment bandpass width in place of the normal one
   a_bpf_assess: assert property (@(posedge clock) disable iff (rst)
      assess_active |=> bandpass_width_active == $past({bank_q[8][1:0], bank_q[9]}))
      else $error("assessment bandpass width wrong");

   // Six trim bits only; the reserved pair stays out
   a_rssi_trim: assert property (@(posedge clock) disable iff (rst)
      1'b1 |=> signal_strength_lowpass_trim == $past(bank_q[10][5:0]))
      else $error("RSSI trim output wrong");

   // Five regulator bits only
   a_pa_fine_code: assert property (@(posedge clock) disable iff (rst)
      1'b1 |=> amp_regulator_fine_code == $past(bank_q[11][4:0]))
      else $error("regulator trim output wrong");

   // Done falls as soon as the amp turns off
   a_ramp_done_clear: assert property (@(posedge clock) disable iff (rst)
      !amp_on_state |=> !amp_ramp_done)
      else $error("ramp done outlived amp-on");

   // Unmapped reads return zero
   a_unmapped_read: assert property (@(posedge clock) disable iff (rst)
      (req && !wb_we_i && !in_bank(wb_adr_i[7:2]) && wb_adr_i[7:2] != IDX_AMP_CTRL_CFG &&
      wb_adr_i[7:2] != IDX_FRONTEND_STATUS) |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   // Every taken request is answered next cycle
   a_ack_follows_req: assert property (@(posedge clock) disable iff (rst)
      req |=> wb_ack_o)
      else $error("request not acked");

   // Masked lane leaves the switch/ramp slot untouched
   a_write_masked: assert property (@(posedge clock) disable iff (rst)
      (req && wb_we_i && !wb_sel_i[0]) |=> bank_q[0] == $past(bank_q[0]))
      else $error("masked write changed a register");

   // Amp-on reference when the timing bit is set
   a_amp_follows_on: assert property (@(posedge clock) disable iff (rst)
      (bank_q[0][POS_AMP_ENABLE] && amp_cfg_q[POS_AMP_TIMING] && !amp_cfg_q[POS_AMP_POLARITY])
      |=> ext_amp_ctrl_pin == $past(amp_on_state))
      else $error("amp pin not following amp-on");

   // Negative logic inverts an enabled transmit-on level
   a_amp_inverted: assert property (@(posedge clock) disable iff (rst)
      (bank_q[0][POS_AMP_ENABLE] && !amp_cfg_q[POS_AMP_TIMING] && amp_cfg_q[POS_AMP_POLARITY])
      |=> ext_amp_ctrl_pin == !$past(tx_on_state))
      else $error("amp pin not inverted");
   c_ramp_done: cover property (@(posedge clock) disable iff (rst) $rose(amp_ramp_done));
   c_assess_read: cover property (@(posedge clock) disable iff (rst) assess_active && wb_ack_o && !wb_we_i);
   c_amp_on: cover property (@(posedge clock) disable iff (rst) $rose(ext_amp_ctrl_pin));
   c_open_drain_low: cover property (@(posedge clock) disable iff (rst) bank_q[0][POS_ANT_MODE] && antenna_switch_pin_oe);
   c_ramp_longest: cover property (@(posedge clock) disable iff (rst) ramp_q == RFT_RAMP_RUN && bank_q[0][3:0] == 4'hf);
endmodule
`default_nettype wire

// File: verif/rft_trim_regs_bench.sv
// Self-checking bench for the RF front-end trim register bank
`default_nettype none
module rft_trim_regs_bench
   import rft_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack;
   logic tx_on = 1'b0, amp_on = 1'b0, assess = 1'b0, nb = 1'b0, ant_lvl = 1'b0, trx_lvl = 1'b0;
   logic [2:0] rate = 3'h0;
   logic ant_o, ant_oe, trx_o, trx_oe, amp_pin, ramp_done;
   logic [2:0] pump;
   logic [18:0] if_act;
   logic [9:0] bpf_act;
   logic [5:0] rssi;
   logic [4:0] pa_fine;
   logic [31:0] r;
   logic [18:0] exp_if;
   int fails = 0;
   int n_checks = 0;
   int cnt, prev, ns, need;
   localparam logic [7:0] DEF [12] = '{RST_SWITCH_RAMP, RST_PUMP_CUR, RST_IF_HIGH, RST_IF_LOW, 8'h14, 8'h47,
      RST_BPF_HIGH, RST_BPF_LOW, RST_BPF_ASSESS_HIGH, RST_BPF_ASSESS_LOW, RST_RSSI_TRIM, RST_PA_FINE};
   // Free-running 50 MHz clock
   always #10 clock = ~clock;
   rft_trim_regs u_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_on_state(tx_on),
      .amp_on_state(amp_on), .assess_active(assess), .rate_code(rate), .narrowband_option(nb),
      .antenna_switch_level(ant_lvl), .txrx_switch_level(trx_lvl), .antenna_switch_pin_o(ant_o),
      .antenna_switch_pin_oe(ant_oe), .txrx_switch_pin_o(trx_o), .txrx_switch_pin_oe(trx_oe),
      .ext_amp_ctrl_pin(amp_pin), .amp_ramp_done(ramp_done), .pump_current_active(pump),
      .intermediate_freq_active(if_act), .bandpass_width_active(bpf_act),
      .signal_strength_lowpass_trim(rssi), .amp_regulator_fine_code(pa_fine));
   task automatic wrap_up();
      if (fails == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] expect_v);
      n_checks++;
      if (seen !== expect_v) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expect_v);
      end
   endtask
   // One classic cycle; request held until ack is sampled, data taken at that edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, input logic s,
      output logic [31:0] q);
      int n;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h00_0000, d};
      sel <= {3'h0, s};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      if (n >= 50) check(32'h0000_0000, 32'h0000_0001);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, 1'b1, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 8'h00, 1'b1, q);
      check(q, {24'h00_0000, e});
   endtask
   // Let registered outputs follow an input or register change
   task automatic settle();
      repeat (3) @(posedge clock);
   endtask
   // Hang guard, far beyond the expected few thousand cycles
   initial begin
      #2000000;
      fails++;
      wrap_up();
   end
   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      settle();
      check({26'h0, rssi}, 32'h0000_001f);
      check({27'h0, pa_fine}, 32'h0000_0010);
      for (int i = 0; i < 12; i++) rd_chk(8'((BANK_FIRST + i) * 4), DEF[i]);
      // Full-byte readback including reserved bits, then unmapped and strobe-masked writes
      for (int i = 0; i < 12; i++) wr(8'((BANK_FIRST + i) * 4), 8'ha5 ^ 8'(i));
      for (int i = 0; i < 12; i++) rd_chk(8'((BANK_FIRST + i) * 4), 8'ha5 ^ 8'(i));
      wr(8'hfc, 8'hff);
      rd_chk(8'hfc, 8'h00);
      xfer(8'h20, 1'b1, 8'h5a, 1'b0, r);
      rd_chk(8'h20, 8'ha5);
      wr(8'h24, 8'h35);
      wr(8'h28, 8'hc3);
      wr(8'h2c, 8'h5a);
      wr(8'h30, 8'h9e);
      wr(8'h34, 8'h21);
      wr(8'h38, 8'hfd);
      wr(8'h3c, 8'h9b);
      wr(8'h40, 8'h02);
      wr(8'h44, 8'h7e);
      wr(8'h48, 8'hea);
      wr(8'h4c, 8'hf3);
      settle();
      check({26'h0, rssi}, 32'h0000_002a);
      check({27'h0, pa_fine}, 32'h0000_0013);
      tx_on <= 1'b1;
      settle();
      check({29'h0, pump}, 32'h0000_0003);
      tx_on <= 1'b0;
      settle();
      check({29'h0, pump}, 32'h0000_0005);
      check({22'h0, bpf_act}, 32'h0000_019b);
      assess <= 1'b1;
      settle();
      check({22'h0, bpf_act}, 32'h0000_027e);
      // Every rate code: scaled IF in both modes, and the narrowband misuse flag
      nb <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         rate <= 3'(c);
         assess <= 1'b0;
         settle();
         exp_if = {3'b000, 16'hc35a} << c[1:0];
         check({13'h0, if_act}, {13'h0, exp_if});
         assess <= 1'b1;
         settle();
         exp_if = {3'b000, 16'h9e21} << c[1:0];
         check({13'h0, if_act}, {13'h0, exp_if});
         xfer(8'h84, 1'b0, 8'h00, 1'b1, r);
         check({31'h0, r[2]}, {31'h0, !(c == 3 || c == 4 || c == 6)});
      end
      nb <= 1'b0;
      assess <= 1'b0;
      // Switch pin drive modes at both desired levels
      for (int m = 0; m < 4; m++) begin
         wr(8'h20, {m[1], m[0], 6'h00});
         for (int l = 0; l < 2; l++) begin
            ant_lvl <= l[0];
            trx_lvl <= ~l[0];
            settle();
            check({30'h0, ant_o, ant_oe}, m[1] ? {31'h0, ~l[0]} : {30'h0, l[0], 1'b1});
            check({30'h0, trx_o, trx_oe}, m[0] ? {31'h0, l[0]} : {30'h0, ~l[0], 1'b1});
         end
      end
      // Amp control pin over enable, polarity, timing and both radio states
      for (int k = 0; k < 32; k++) begin
         wr(8'h20, {3'b000, k[0], 4'h0});
         wr(8'h80, {k[2], k[1], 6'h00});
         tx_on <= k[3];
         amp_on <= k[4];
         settle();
         check({31'h0, amp_pin}, {31'h0, (k[0] & (k[2] ? k[4] : k[3])) ^ k[1]});
      end
      amp_on <= 1'b0;
      tx_on <= 1'b0;
      wr(8'h80, 8'h00);
      // Ramp length for codes 0, 1, 2 and 15, measured from the amp-on rise
      prev = 0;
      foreach (DEF[j]) if (j < 4) begin
         cnt = (j == 3) ? 15 : j;
         ns = (cnt == 0) ? RAMP_BASE_NS : RAMP_FIRST_NS + (cnt - 1) * RAMP_STEP_NS;
         need = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
         wr(8'h20, 8'(cnt));
         settle();
         @(posedge clock);
         amp_on <= 1'b1;
         cnt = 0;
         do begin
            @(posedge clock);
            cnt++;
         end while (ramp_done !== 1'b1 && cnt < 2000);
         check({31'h0, cnt >= need && cnt <= need + 2}, 32'h0000_0001);
         check({31'h0, cnt > prev}, 32'h0000_0001);
         prev = cnt;
         amp_on <= 1'b0;
         settle();
         check({31'h0, ramp_done}, 32'h0000_0000);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
